// ---- cad_decode.sv ----
// Decode and execute for load, table read, add, carry, logic, bit, compare and branch groups.
`timescale 1ns/1ns
`default_nettype none
module cad_decode (
	input  wire logic              CLK_SYS,
	input  wire logic              RESETN,
	input  wire logic              INSTR_VALID,
	input  wire logic [8:0]        INSTR,
	input  wire logic [3:0]        MEM_RDATA,
	input  wire logic [3:0]        PORT_S,
	input  wire logic [1:0]        GATE_SEL,
	input  wire logic [2:0]        DREG_LOW,
	input  wire logic [7:0]        ROM_RDATA,
	output cad_pkg::cad_memwr_s    MEM_WR,
	output cad_pkg::cad_pc_s       PC_LOAD_VAL,
	output logic                   PC_LOAD,
	output logic [10:0]            ROM_ADDR,
	output logic                   ROM_RD,
	output logic                   STACK_PUSH,
	output logic                   STACK_POP,
	output logic [3:0]             ACC,
	output logic [3:0]             BREG,
	output logic                   CARRY_FLAG,
	output logic                   SKIP,
	output logic                   BUSY
);
	////////////////////////////////////////////////////////////////////////////////
	cad_pkg::cad_state_e  state_ff, nxt_state;
	cad_pkg::cad_second_e second_ff, nxt_second;
	logic [3:0]           acc_ff, nxt_acc, breg_ff, nxt_breg, hold_ff, nxt_hold;
	logic                 carry_ff, nxt_carry, skip_ff, nxt_skip, last_load_ff, nxt_last_load;
	cad_pkg::cad_memwr_s  memwr_ff, nxt_memwr;
	cad_pkg::cad_pc_s     pcv_ff, nxt_pcv;
	logic                 pcl_ff, nxt_pcl, rrd_ff, nxt_rrd, push_ff, nxt_push, pop_ff, nxt_pop;
	logic [10:0]          raddr_ff, nxt_raddr;
	logic [4:0]           sum;
	logic [1:0]           j;
	logic                 exec;
	logic                 busy_ff, nxt_busy;
	logic [3:0]           port_s_meta_ff, port_s_sync_ff;

	assign j = INSTR[1:0];
	assign exec = INSTR_VALID && !skip_ff;

	always_comb begin
		nxt_state     = state_ff;
		nxt_second    = second_ff;
		nxt_acc       = acc_ff;
		nxt_breg      = breg_ff;
		nxt_hold      = hold_ff;
		nxt_carry     = carry_ff;
		nxt_skip      = skip_ff;
		nxt_last_load = last_load_ff;
		nxt_memwr     = '0;
		nxt_pcv       = pcv_ff;
		nxt_pcl       = 1'b0;
		nxt_rrd       = 1'b0;
		nxt_push      = 1'b0;
		nxt_pop       = 1'b0;
		nxt_raddr     = raddr_ff;
		sum           = 5'h00;
		case (state_ff)
			cad_pkg::ST_RUN: begin
				if (INSTR_VALID) begin
					nxt_skip = 1'b0;
					nxt_last_load = INSTR[8:4] == cad_pkg::PFX_LOAD_IMM;
					if (skip_ff) begin
						nxt_skip = 1'b0;
					end else if (INSTR[8:4] == cad_pkg::PFX_LOAD_IMM) begin
						if (!last_load_ff)
							nxt_acc = INSTR[3:0];
					end else if (INSTR[8:4] == cad_pkg::PFX_TABLE_READ) begin
						nxt_raddr = {INSTR[3:0], DREG_LOW, acc_ff};
						nxt_rrd   = 1'b1;
						nxt_push  = 1'b1;
						nxt_state = cad_pkg::ST_TABLE;
					end else if (INSTR[8:4] == cad_pkg::PFX_ADD_IMM) begin
						sum      = {1'b0, acc_ff} + {1'b0, INSTR[3:0]};
						nxt_acc  = sum[3:0];
						nxt_skip = !sum[4];
					end else if (INSTR[8:4] == cad_pkg::PFX_LONG_JUMP) begin
						nxt_hold   = INSTR[3:0];
						nxt_second = cad_pkg::SW_LJUMP;
						nxt_state  = cad_pkg::ST_SECOND;
					end else if (INSTR[8:2] == cad_pkg::PFX_SET_BIT) begin
						nxt_memwr.we    = 1'b1;
						nxt_memwr.wdata = MEM_RDATA | (4'h1 << j);
					end else if (INSTR[8:2] == cad_pkg::PFX_CLR_BIT) begin
						nxt_memwr.we    = 1'b1;
						nxt_memwr.wdata = MEM_RDATA & ~(4'h1 << j);
					end else if (INSTR[8:2] == cad_pkg::PFX_TEST_BIT) begin
						nxt_skip = !MEM_RDATA[j];
					end else if (INSTR[8:7] == cad_pkg::PFX_SHORT_JUMP) begin
						nxt_pcv.offset = INSTR[6:0];
						nxt_pcl        = 1'b1;
					end else begin
						case (INSTR)
							cad_pkg::OP_ADD_MEMORY: begin
								sum     = {1'b0, acc_ff} + {1'b0, MEM_RDATA};
								nxt_acc = sum[3:0];
							end
							cad_pkg::OP_ADD_CARRY: begin
								sum       = {1'b0, acc_ff} + {1'b0, MEM_RDATA} + {4'h0, carry_ff};
								nxt_acc   = sum[3:0];
								nxt_carry = sum[4];
							end
							cad_pkg::OP_SET_CARRY:   nxt_carry = 1'b1;
							cad_pkg::OP_CLEAR_CARRY: nxt_carry = 1'b0;
							cad_pkg::OP_TEST_CARRY:  nxt_skip = !carry_ff;
							cad_pkg::OP_COMPLEMENT:  nxt_acc = ~acc_ff;
							cad_pkg::OP_ROTATE: begin
								nxt_acc   = {carry_ff, acc_ff[3:1]};
								nxt_carry = acc_ff[0];
							end
							cad_pkg::OP_LOGIC_PORT: begin
								case (GATE_SEL)
									cad_pkg::GATE_XOR: nxt_acc = acc_ff ^ port_s_sync_ff;
									cad_pkg::GATE_OR:  nxt_acc = acc_ff | port_s_sync_ff;
									default:           nxt_acc = acc_ff & port_s_sync_ff;
								endcase
							end
							cad_pkg::OP_CMP_MEM: nxt_skip = acc_ff == MEM_RDATA;
							cad_pkg::OP_CMP_IMM: begin
								nxt_second = cad_pkg::SW_CMP_IMM;
								nxt_state  = cad_pkg::ST_SECOND;
							end
							cad_pkg::OP_JUMP_ACC: begin
								nxt_second = cad_pkg::SW_JUMP_ACC;
								nxt_state  = cad_pkg::ST_SECOND;
							end
							cad_pkg::OP_LJUMP_ACC: begin
								nxt_second = cad_pkg::SW_LJUMP_ACC;
								nxt_state  = cad_pkg::ST_SECOND;
							end
							default: ;
						endcase
					end
				end
			end
			cad_pkg::ST_SECOND: begin
				if (INSTR_VALID) begin
					nxt_state     = cad_pkg::ST_RUN;
					nxt_last_load = 1'b0;
					case (second_ff)
						cad_pkg::SW_CMP_IMM: nxt_skip = acc_ff == INSTR[3:0];
						cad_pkg::SW_LJUMP: begin
							nxt_pcv = {hold_ff, INSTR[6:0]};
							nxt_pcl = 1'b1;
						end
						cad_pkg::SW_JUMP_ACC: begin
							nxt_pcv.offset = {INSTR[6:4], acc_ff};
							nxt_pcl        = 1'b1;
						end
						cad_pkg::SW_LJUMP_ACC: begin
							nxt_pcv = {INSTR[3:0], INSTR[6:4], acc_ff};
							nxt_pcl = 1'b1;
						end
						default: ;
					endcase
					nxt_second = cad_pkg::SW_NONE;
				end
			end
			cad_pkg::ST_TABLE: begin
				nxt_breg  = ROM_RDATA[7:4];
				nxt_acc   = ROM_RDATA[3:0];
				nxt_pop   = 1'b1;
				nxt_state = cad_pkg::ST_RESTORE;
			end
			cad_pkg::ST_RESTORE: begin
				nxt_last_load = 1'b0;
				nxt_state     = cad_pkg::ST_RUN;
			end
			default: nxt_state = cad_pkg::ST_RUN;
		endcase
		nxt_busy = nxt_state != cad_pkg::ST_RUN;
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			state_ff     <= cad_pkg::ST_RUN;
			second_ff    <= cad_pkg::SW_NONE;
			acc_ff       <= cad_pkg::RST_NIBBLE;
			breg_ff      <= cad_pkg::RST_NIBBLE;
			hold_ff      <= cad_pkg::RST_PAGE;
			carry_ff     <= 1'b0;
			skip_ff      <= 1'b0;
			last_load_ff <= 1'b0;
			memwr_ff     <= '0;
			pcv_ff       <= {cad_pkg::RST_PAGE, cad_pkg::RST_OFFSET};
			pcl_ff       <= 1'b0;
			rrd_ff       <= 1'b0;
			push_ff      <= 1'b0;
			pop_ff       <= 1'b0;
			raddr_ff     <= '0;
			busy_ff      <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			second_ff    <= nxt_second;
			acc_ff       <= nxt_acc;
			breg_ff      <= nxt_breg;
			hold_ff      <= nxt_hold;
			carry_ff     <= nxt_carry;
			skip_ff      <= nxt_skip;
			last_load_ff <= nxt_last_load;
			memwr_ff     <= nxt_memwr;
			pcv_ff       <= nxt_pcv;
			pcl_ff       <= nxt_pcl;
			rrd_ff       <= nxt_rrd;
			push_ff      <= nxt_push;
			pop_ff       <= nxt_pop;
			raddr_ff     <= nxt_raddr;
			busy_ff      <= nxt_busy;
		end
	end

	// Port S comes from a pin, so two flops settle it before the gate logic reads it.
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			port_s_meta_ff <= cad_pkg::RST_NIBBLE;
			port_s_sync_ff <= cad_pkg::RST_NIBBLE;
		end else begin
			port_s_meta_ff <= PORT_S;
			port_s_sync_ff <= port_s_meta_ff;
		end
	end

	assign MEM_WR      = memwr_ff;
	assign PC_LOAD_VAL = pcv_ff;
	assign PC_LOAD     = pcl_ff;
	assign ROM_ADDR    = raddr_ff;
	assign ROM_RD      = rrd_ff;
	assign STACK_PUSH  = push_ff;
	assign STACK_POP   = pop_ff;
	assign ACC         = acc_ff;
	assign BREG        = breg_ff;
	assign CARRY_FLAG  = carry_ff;
	assign SKIP        = skip_ff;
	assign BUSY        = busy_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	logic run_exec;
	assign run_exec = exec && state_ff == cad_pkg::ST_RUN;

	sequence s_table_start;
		run_exec && INSTR[8:4] == cad_pkg::PFX_TABLE_READ;
	endsequence
	sequence s_table_end;
		STACK_PUSH ##1 STACK_POP;
	endsequence

	a_table_stack: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		s_table_start |=> s_table_end) else $error("table read stack use wrong");
	a_table_data: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		STACK_POP |-> ACC == $past(ROM_RDATA[3:0]) && BREG == $past(ROM_RDATA[7:4]))
		else $error("table read data wrong");
	a_load_repeat: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		run_exec && INSTR[8:4] == cad_pkg::PFX_LOAD_IMM && last_load_ff |=> $stable(ACC))
		else $error("repeated load changed accumulator");
	a_add_mem: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		run_exec && INSTR == cad_pkg::OP_ADD_MEMORY |=> ACC == 4'($past(acc_ff) + $past(MEM_RDATA))
		&& $stable(CARRY_FLAG)) else $error("add memory wrong");
	a_add_imm_skip: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		run_exec && INSTR[8:4] == cad_pkg::PFX_ADD_IMM |=> SKIP == ({1'b0, $past(acc_ff)}
		+ {1'b0, $past(INSTR[3:0])} < 5'h10)) else $error("add immediate skip wrong");
	a_carry_test: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		run_exec && INSTR == cad_pkg::OP_TEST_CARRY |=> SKIP == !$past(carry_ff))
		else $error("carry test wrong");
	a_rotate: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		run_exec && INSTR == cad_pkg::OP_ROTATE |=> {ACC, CARRY_FLAG} == $past({carry_ff, acc_ff}))
		else $error("rotate wrong");
	a_skip_noop: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		INSTR_VALID && skip_ff && state_ff == cad_pkg::ST_RUN |=> $stable(ACC) && $stable(CARRY_FLAG)
		&& !MEM_WR.we && !PC_LOAD) else $error("skipped instruction had effect");
	a_bit_set: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		run_exec && INSTR[8:2] == cad_pkg::PFX_SET_BIT |=> MEM_WR.we && MEM_WR.wdata[$past(j)])
		else $error("set bit wrong");
	a_bit_clear: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		run_exec && INSTR[8:2] == cad_pkg::PFX_CLR_BIT |=> MEM_WR.we && !MEM_WR.wdata[$past(j)]
		&& (MEM_WR.wdata | (4'h1 << $past(j))) == ($past(MEM_RDATA) | (4'h1 << $past(j))))
		else $error("clear bit wrong");
	a_cmp_mem: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		run_exec && INSTR == cad_pkg::OP_CMP_MEM |=> SKIP == ($past(acc_ff) == $past(MEM_RDATA)))
		else $error("compare memory wrong");
endmodule : cad_decode
`default_nettype wire

// ---- cad_decode_bench.sv ----
// Self-checking bench for the decoder with a ROM and RAM model.
`timescale 1ns/1ns
`default_nettype none
module cad_decode_bench;
	logic                clk_sys = 1'b0;
	logic                resetn = 1'b0;
	logic                ivld = 1'b0;
	logic [8:0]          instr = 9'h000;
	logic [3:0]          port_s = 4'h6;
	logic [1:0]          gsel = 2'h0;
	logic [2:0]          dlow = 3'h0;
	logic                pre_en = 1'b0;
	logic [3:0]          pre_v = 4'h0;
	logic [3:0]          mrd, acc, breg;
	logic [7:0]          romd;
	cad_pkg::cad_memwr_s mwr;
	cad_pkg::cad_pc_s    pcv;
	logic                program_counter_low, rrd, push, pop, cy, skip, busy;
	logic [10:0]         radr;
	int                  mismatches = 0;
	int                  tests_run = 0;
	int                  cycles = 0;

	cad_decode DUT (.CLK_SYS(clk_sys), .RESETN(resetn), .INSTR_VALID(ivld), .INSTR(instr),
		.MEM_RDATA(mrd), .PORT_S(port_s), .GATE_SEL(gsel), .DREG_LOW(dlow), .ROM_RDATA(romd),
		.MEM_WR(mwr), .PC_LOAD_VAL(pcv), .PC_LOAD(program_counter_low), .ROM_ADDR(radr), .ROM_RD(rrd),
		.STACK_PUSH(push), .STACK_POP(pop), .ACC(acc), .BREG(breg), .CARRY_FLAG(cy),
		.SKIP(skip), .BUSY(busy));
	cad_mem_model u_mem (.clk_sys(clk_sys), .preset_en(pre_en), .preset_val(pre_v), .mem_wr(mwr),
		.rom_rd(rrd), .rom_addr(radr), .mem_rdata(mrd), .rom_rdata(romd));

	initial forever #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			mismatches++;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk_v(input logic [10:0] got, input logic [10:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t value %h want %h", $time, got, exp);
		end
	endtask : chk_v
	task automatic chk_b(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t flag %b want %b", $time, got, exp);
		end
	endtask : chk_b
	task automatic issue(input logic [8:0] w);
		@(posedge clk_sys);
		ivld <= 1'b1;
		instr <= w;
		@(posedge clk_sys);
		ivld <= 1'b0;
		#1;
	endtask : issue
	task automatic setm(input logic [3:0] v);
		@(posedge clk_sys);
		pre_en <= 1'b1;
		pre_v <= v;
		@(posedge clk_sys);
		pre_en <= 1'b0;
		#1;
	endtask : setm
	task automatic lda(input logic [3:0] n);
		issue(cad_pkg::OP_CLEAR_CARRY);
		issue({cad_pkg::PFX_LOAD_IMM, n});
	endtask : lda
	////////////////////////////////////////////////////////////////
	task automatic t_load;
		lda(4'h5);
		chk_v(11'(acc), 11'h5);
		issue({cad_pkg::PFX_LOAD_IMM, 4'h9});
		issue({cad_pkg::PFX_LOAD_IMM, 4'h7});
		chk_v(11'(acc), 11'h5);
	endtask : t_load
	task automatic t_arith;
		setm(4'hc);
		issue(cad_pkg::OP_ADD_MEMORY);
		chk_v(11'(acc), 11'h1);
		chk_b(cy, 1'b0);
		issue(cad_pkg::OP_SET_CARRY);
		chk_b(cy, 1'b1);
		chk_v(11'(acc), 11'h1);
		issue(cad_pkg::OP_ADD_CARRY);
		chk_v(11'(acc), 11'he);
		chk_b(cy, 1'b0);
		issue(cad_pkg::OP_ADD_CARRY);
		chk_v(11'(acc), 11'ha);
		chk_b(cy, 1'b1);
		issue({cad_pkg::PFX_ADD_IMM, 4'h3});
		chk_v(11'(acc), 11'hd);
		chk_b(skip, 1'b1);
		issue(cad_pkg::OP_COMPLEMENT);
		chk_v(11'(acc), 11'hd);
		issue({cad_pkg::PFX_ADD_IMM, 4'h5});
		chk_v(11'(acc), 11'h2);
		chk_b(skip, 1'b0);
		chk_b(cy, 1'b1);
	endtask : t_arith
	task automatic t_rot;
		issue(cad_pkg::OP_COMPLEMENT);
		chk_v(11'(acc), 11'hd);
		chk_b(cy, 1'b1);
		issue(cad_pkg::OP_ROTATE);
		chk_v(11'(acc), 11'he);
		chk_b(cy, 1'b1);
		issue(cad_pkg::OP_ROTATE);
		chk_v(11'(acc), 11'hf);
		chk_b(cy, 1'b0);
		issue(cad_pkg::OP_TEST_CARRY);
		chk_b(skip, 1'b1);
		issue(cad_pkg::OP_SET_CARRY);
		chk_b(cy, 1'b0);
		issue(cad_pkg::OP_SET_CARRY);
		issue(cad_pkg::OP_TEST_CARRY);
		chk_b(skip, 1'b0);
	endtask : t_rot
	task automatic t_logic;
		for (int g = 0; g < 4; g++) begin
			lda(4'ha);
			@(posedge clk_sys);
			gsel <= 2'(g);
			issue(cad_pkg::OP_LOGIC_PORT);
			chk_v(11'(acc), g == 0 ? 11'hc : g == 1 ? 11'he : 11'h2);
		end
	endtask : t_logic
	task automatic t_bits;
		for (int j = 0; j < 4; j++) begin
			setm(4'h0);
			issue({cad_pkg::PFX_TEST_BIT, 2'(j)});
			chk_b(skip, 1'b1);
			issue(cad_pkg::OP_CLEAR_CARRY);
			issue({cad_pkg::PFX_SET_BIT, 2'(j)});
			chk_b(mwr.we, 1'b1);
			chk_v(11'(mwr.wdata), 11'(1 << j));
			issue({cad_pkg::PFX_TEST_BIT, 2'(j)});
			chk_b(skip, 1'b0);
			setm(4'hf);
			issue({cad_pkg::PFX_CLR_BIT, 2'(j)});
			chk_b(mwr.we, 1'b1);
			chk_v(11'(mwr.wdata), 11'(4'hf & ~(4'h1 << j)));
		end
	endtask : t_bits
	task automatic t_cmp;
		setm(4'h7);
		lda(4'h7);
		issue(cad_pkg::OP_CMP_MEM);
		chk_b(skip, 1'b1);
		issue(cad_pkg::OP_CLEAR_CARRY);
		setm(4'h8);
		issue(cad_pkg::OP_CMP_MEM);
		chk_b(skip, 1'b0);
		for (int k = 0; k < 2; k++) begin
			issue(cad_pkg::OP_CMP_IMM);
			chk_b(busy, 1'b1);
			issue({cad_pkg::PFX_LOAD_IMM, k == 0 ? 4'h7 : 4'h3});
			chk_b(skip, k == 0);
			chk_v(11'(acc), 11'h7);
			issue(cad_pkg::OP_CLEAR_CARRY);
		end
	endtask : t_cmp
	task automatic t_branch;
		issue({cad_pkg::PFX_SHORT_JUMP, 7'h5a});
		chk_b(program_counter_low, 1'b1);
		chk_v(11'(pcv.offset), 11'h5a);
		issue({cad_pkg::PFX_LONG_JUMP, 4'hb});
		chk_b(program_counter_low, 1'b0);
		issue({2'h3, 7'h33});
		chk_b(program_counter_low, 1'b1);
		chk_v(pcv, 11'h5b3);
		issue(cad_pkg::OP_JUMP_ACC);
		issue({2'h3, 3'h5, 4'h0});
		chk_b(program_counter_low, 1'b1);
		chk_v(11'(pcv.offset), 11'h57);
		issue(cad_pkg::OP_LJUMP_ACC);
		issue({2'h3, 3'h2, 4'h9});
		chk_b(program_counter_low, 1'b1);
		chk_v(pcv, 11'h4a7);
	endtask : t_branch
	task automatic t_table;
		logic [10:0] a;
		logic [7:0]  d;
		a = {4'h6, 3'h5, 4'h9};
		d = a[7:0] + {a[10:7], 4'h3};
		@(posedge clk_sys);
		dlow <= 3'h5;
		lda(4'h9);
		issue({cad_pkg::PFX_TABLE_READ, 4'h6});
		chk_b(rrd, 1'b1);
		chk_b(push, 1'b1);
		chk_v(radr, a);
		@(posedge clk_sys);
		#1;
		chk_b(pop, 1'b1);
		chk_b(busy, 1'b1);
		chk_v(11'(acc), 11'(d[3:0]));
		chk_v(11'(breg), 11'(d[7:4]));
	endtask : t_table
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		t_load();
		t_arith();
		t_rot();
		t_logic();
		t_bits();
		t_cmp();
		t_branch();
		t_table();
		wrap_up();
	end
endmodule : cad_decode_bench
`default_nettype wire

// ---- cad_mem_model.sv ----
// Behavioural program ROM and data RAM nibble facing the decoder.
`timescale 1ns/1ns
`default_nettype none
module cad_mem_model (
	input  wire logic                clk_sys,
	input  wire logic                preset_en,
	input  wire logic [3:0]          preset_val,
	input  wire cad_pkg::cad_memwr_s mem_wr,
	input  wire logic                rom_rd,
	input  wire logic [10:0]         rom_addr,
	output logic [3:0]               mem_rdata,
	output logic [7:0]               rom_rdata
);
	logic [3:0] mem_q = 4'h0;
	logic [7:0] idle_q = 8'h00;
	// The ROM answers in the cycle that holds the address and the read strobe.
	// Outside a read the ROM bus flips every cycle, so stale data never looks valid.
	always @(posedge clk_sys) begin
		if (preset_en)
			mem_q <= preset_val;
		else if (mem_wr.we)
			mem_q <= mem_wr.wdata;
		idle_q <= ~idle_q;
	end
	assign rom_rdata = rom_rd ? rom_addr[7:0] + {rom_addr[10:7], 4'h3} : idle_q;
	assign mem_rdata = mem_q;
endmodule : cad_mem_model
`default_nettype wire

// ---- cad_pkg.sv ----
// Package with opcodes, widths and carriers for the arithmetic, bit and branch decoder.
package cad_pkg;
	localparam int IW = 9;
	localparam logic [8:0] OP_ADD_MEMORY   = 9'h00a;
	localparam logic [8:0] OP_ADD_CARRY    = 9'h00b;
	localparam logic [8:0] OP_SET_CARRY    = 9'h007;
	localparam logic [8:0] OP_CLEAR_CARRY  = 9'h006;
	localparam logic [8:0] OP_TEST_CARRY   = 9'h02f;
	localparam logic [8:0] OP_COMPLEMENT   = 9'h01c;
	localparam logic [8:0] OP_ROTATE       = 9'h01d;
	localparam logic [8:0] OP_LOGIC_PORT   = 9'h041;
	localparam logic [8:0] OP_CMP_MEM      = 9'h026;
	localparam logic [8:0] OP_CMP_IMM      = 9'h025;
	localparam logic [8:0] OP_JUMP_ACC     = 9'h001;
	localparam logic [8:0] OP_LJUMP_ACC    = 9'h010;
	localparam logic [4:0] PFX_LOAD_IMM    = 5'h0b;
	localparam logic [4:0] PFX_TABLE_READ  = 5'h09;
	localparam logic [4:0] PFX_ADD_IMM     = 5'h0a;
	localparam logic [4:0] PFX_LONG_JUMP   = 5'h03;
	localparam logic [6:0] PFX_SET_BIT     = 7'h17;
	localparam logic [6:0] PFX_CLR_BIT     = 7'h13;
	localparam logic [6:0] PFX_TEST_BIT    = 7'h08;
	localparam logic [1:0] PFX_SHORT_JUMP  = 2'h3;
	localparam logic [1:0] GATE_XOR        = 2'h0;
	localparam logic [1:0] GATE_OR         = 2'h1;
	localparam logic [3:0] RST_NIBBLE      = 4'h0;
	localparam logic [3:0] RST_PAGE        = 4'h0;
	localparam logic [6:0] RST_OFFSET      = 7'h00;
	localparam logic [9:0] RST_SAVE        = 10'h000;

	typedef enum {ST_RUN, ST_SECOND, ST_TABLE, ST_RESTORE} cad_state_e;
	typedef enum {SW_NONE, SW_CMP_IMM, SW_LJUMP, SW_JUMP_ACC, SW_LJUMP_ACC} cad_second_e;

	// Data memory write request toward the nibble at the data pointer.
	typedef struct packed {
		logic       we;
		logic [3:0] wdata;
	} cad_memwr_s;

	// Program counter split into page and offset.
	typedef struct packed {
		logic [3:0] page;
		logic [6:0] offset;
	} cad_pc_s;
endpackage : cad_pkg
